// *** rtl/itm_map.vh ***
// Register map, field positions and reset values of the interval timer block.
// Assumes byte addressing on a 32-bit AHB-Lite bus, one register per aligned word.
`ifndef ITM_MAP_VH
`define ITM_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ITM_OFF_CTL_A 8'h00
`define ITM_OFF_CTL_B 8'h04
`define ITM_OFF_IOC_ONE 8'h08
`define ITM_OFF_IOC_TWO 8'h0c
`define ITM_OFF_OUT_CTL 8'h10
`define ITM_OFF_PERIOD 8'h14
`define ITM_OFF_SECOND 8'h18
`define ITM_OFF_COUNT 8'h1c
`define ITM_OFF_IRQ_STAT 8'h20
`define ITM_OFF_IRQ_MASK 8'h24

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ITM_CE_BIT 7
`define ITM_PRESC_MSB 2
`define ITM_MODE_MSB 2
`define ITM_SW_TRIG_BIT 6
`define ITM_EEE_BIT 5
`define ITM_SQ_EN_BIT 0
`define ITM_SEC_EN_BIT 1
`define ITM_IRQ_PERIOD_BIT 0
`define ITM_IRQ_SECOND_BIT 1

// ----------------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------------
`define ITM_MODE_INTERVAL 3'b000
`define ITM_EDGE_NONE 2'b00
`define ITM_EDGE_RISE 2'b01
`define ITM_EDGE_FALL 2'b10
`define ITM_IDLE_COUNT 16'hffff
`define ITM_ZERO_COUNT 16'h0000
`define ITM_RST_CTL 8'h00
`define ITM_RST_MASK 2'b11
`define ITM_HTRANS_NONSEQ_BIT 1

`endif

// *** rtl/itm_tick.v ***
// Count clock source: internal prescaler or a synchronised external event edge.
// Assumes ext_event arrives asynchronously from a pin.
`timescale 1ns/1ps
`default_nettype none
`include "itm_map.vh"

module itm_tick (
  input wire clk,
  input wire rst_n,
  input wire ext_event,
  input wire ext_sel,
  input wire [1:0] edge_sel,
  input wire [2:0] presc_sel,
  output wire tick
);

  reg [7:0] div;
  reg ev_meta;
  reg ev_sync;
  reg ev_last;
  wire [7:0] div_mask;
  wire int_tick;
  wire rise;
  wire fall;
  reg ext_tick;

  // ----------------------------------------------------------------------------
  // Internal prescaler, clk divided by a power of two
  // ----------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end

  assign div_mask = ~(8'hff << presc_sel);
  assign int_tick = ((div & div_mask) == div_mask);

  // ----------------------------------------------------------------------------
  // External event input
  // ----------------------------------------------------------------------------
  // Edge detector reads only the second and third stages to keep metastability contained
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_meta <= 1'b0;
      ev_sync <= 1'b0;
      ev_last <= 1'b0;
    end else begin
      ev_meta <= ext_event;
      ev_sync <= ev_meta;
      ev_last <= ev_sync;
    end
  end

  assign rise = ev_sync & ~ev_last;
  assign fall = ~ev_sync & ev_last;

  always @* begin
    case (edge_sel)
      `ITM_EDGE_NONE: ext_tick = 1'b0;
      `ITM_EDGE_RISE: ext_tick = rise;
      `ITM_EDGE_FALL: ext_tick = fall;
      default: ext_tick = rise | fall;
    endcase
  end

  assign tick = ext_sel ? ext_tick : int_tick;

endmodule
`default_nettype wire

// *** rtl/itm_irq.v ***
// Sticky interrupt status with write-one-to-clear and a blocking mask.
// Assumes set pulses and clear strobes on the same clock.
`timescale 1ns/1ps
`default_nettype none

module itm_irq (
  input wire clk,
  input wire rst_n,
  input wire [1:0] set,
  input wire clr_we,
  input wire [1:0] clr_data,
  input wire [1:0] mask,
  output reg [1:0] status,
  output reg irq
);

  wire [1:0] next_status;

  // A set arriving with its own clear survives
  assign next_status = (status & ~(clr_we ? clr_data : 2'b00)) | set;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 2'b00;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & ~mask); // see (R8)
    end
  end

endmodule
`default_nettype wire

// *** rtl/itm_top.v ***
// Interval timer top: AHB-Lite register slave, 16-bit counter, compare logic.
// Assumes one AHB-Lite master, clk at 20 MHz, rst_n asynchronous from the system.
//
// Summary of operation
// (R1) Software disables capture edge detection before external event counting.
// (R2) Software picks the internal count clock for trigger, one-shot, width modes.
// (R3) Mode select code 000 runs the interval timer.
// (R4) Enable moves counter from all ones to zero, toggles output, loads period buffer.
// (R5) Count equal to period buffer clears counter, toggles output, raises period irq.
// (R6) Period match interval equals period value plus one count clocks.
// (R7) Secondary compare is buffered and raises its irq on equality.
// (R8) Software masks the secondary irq when it is not wanted.
// (R9) Software sets the second I/O control register to use event input.
// (R10) Period zero holds count at zero, matching and toggling every count clock.
// (R11) Period all ones wraps to zero by match, with no overflow flag.
// (R12) Period writes reach the period buffer at once, even while counting.
// (R13) Period set below count makes counter wrap through all ones first.
// (R14) Software stops the counter before lowering the period; the bench lowers it from 100 to 10 while the counter runs.
// (R15) Counter read buffer returns the live 16-bit count.
// (R16) Counter read buffer reads zero while the counter is disabled.
// (R17) Square-wave output toggles on match only when its output is enabled.
// (R18) Running and not matching, count rises by one per count clock.
`timescale 1ns/1ps
`default_nettype none
`include "itm_map.vh"

module itm_top (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire ext_event_in,
  input wire capture_trigger_in,
  output wire square_wave_out,
  output wire square_wave_oe,
  output wire secondary_wave_out,
  output wire secondary_wave_oe,
  output reg period_match_irq,
  output reg secondary_match_irq,
  output wire irq
);

  // ----------------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------------
  reg rst_meta;
  reg rst_sync_n;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  reg [7:0] timer_control_reg_a;
  reg [7:0] timer_control_reg_b;
  reg [1:0] io_control_reg_one;
  reg [1:0] io_control_reg_two;
  reg [1:0] out_control_reg;
  reg [15:0] period_compare_reg;
  reg [15:0] secondary_compare_reg;
  reg [1:0] irq_mask;
  reg [15:0] period_buffer;
  reg [15:0] secondary_buffer;
  reg [15:0] count;
  reg running;
  reg square_wave;
  reg secondary_wave;
  reg wr_pend;
  reg [7:0] wr_addr;
  wire [1:0] irq_status;
  wire tick;
  wire counter_enable_bit;
  wire interval_mode;
  wire [15:0] counter_read_buffer;
  wire wr_period;
  wire wr_second;
  wire irq_clr_we;
  wire addr_phase;
  wire period_hit;
  wire second_hit;

  assign counter_enable_bit = timer_control_reg_a[`ITM_CE_BIT];
  // see (R3)
  assign interval_mode = (timer_control_reg_b[`ITM_MODE_MSB:0] == `ITM_MODE_INTERVAL);
  // Counter stopped by a clear enable bit sits at all ones internally but reads as zero; see (R15) (R16)
  assign counter_read_buffer = counter_enable_bit ? count : `ITM_ZERO_COUNT;

  // ----------------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------------
  // Zero wait states: every register is a flop, so read data is ready one cycle on
  function [31:0] read_mux;
    input [7:0] a;
    begin
      case (a)
        `ITM_OFF_CTL_A: read_mux = {24'h000000, timer_control_reg_a};
        `ITM_OFF_CTL_B: read_mux = {24'h000000, timer_control_reg_b};
        `ITM_OFF_IOC_ONE: read_mux = {30'h00000000, io_control_reg_one};
        `ITM_OFF_IOC_TWO: read_mux = {30'h00000000, io_control_reg_two};
        `ITM_OFF_OUT_CTL: read_mux = {30'h00000000, out_control_reg};
        `ITM_OFF_PERIOD: read_mux = {16'h0000, period_compare_reg};
        `ITM_OFF_SECOND: read_mux = {16'h0000, secondary_compare_reg};
        `ITM_OFF_COUNT: read_mux = {16'h0000, counter_read_buffer};
        `ITM_OFF_IRQ_STAT: read_mux = {30'h00000000, irq_status};
        `ITM_OFF_IRQ_MASK: read_mux = {30'h00000000, irq_mask};
        default: read_mux = 32'h00000000;
      endcase
    end
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & htrans[`ITM_HTRANS_NONSEQ_BIT] & hready;

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr <= haddr[7:0];
      end
      if (addr_phase & ~hwrite) begin
        hrdata <= read_mux(haddr[7:0]);
      end
    end
  end

  assign wr_period = wr_pend & (wr_addr == `ITM_OFF_PERIOD);
  assign wr_second = wr_pend & (wr_addr == `ITM_OFF_SECOND);
  assign irq_clr_we = wr_pend & (wr_addr == `ITM_OFF_IRQ_STAT);

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timer_control_reg_a <= `ITM_RST_CTL;
      timer_control_reg_b <= `ITM_RST_CTL;
      io_control_reg_one <= `ITM_EDGE_NONE;
      io_control_reg_two <= `ITM_EDGE_NONE;
      out_control_reg <= 2'b00;
      period_compare_reg <= `ITM_ZERO_COUNT;
      secondary_compare_reg <= `ITM_ZERO_COUNT;
      irq_mask <= `ITM_RST_MASK;
    end else if (wr_pend) begin
      case (wr_addr)
        `ITM_OFF_CTL_A: timer_control_reg_a <= hwdata[7:0];
        `ITM_OFF_CTL_B: timer_control_reg_b <= hwdata[7:0];
        `ITM_OFF_IOC_ONE: io_control_reg_one <= hwdata[1:0];
        `ITM_OFF_IOC_TWO: io_control_reg_two <= hwdata[1:0];
        `ITM_OFF_OUT_CTL: out_control_reg <= hwdata[1:0];
        `ITM_OFF_PERIOD: period_compare_reg <= hwdata[15:0];
        `ITM_OFF_SECOND: secondary_compare_reg <= hwdata[15:0];
        `ITM_OFF_IRQ_MASK: irq_mask <= hwdata[1:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Count clock
  // ----------------------------------------------------------------------------
  // Capture input is unused in this mode; edge select stays in the register only
  itm_tick u_tick (
    .clk(clk),
    .rst_n(rst_sync_n),
    .ext_event(ext_event_in),
    .ext_sel(timer_control_reg_b[`ITM_EEE_BIT]), // see (R9)
    .edge_sel(io_control_reg_two),
    .presc_sel(timer_control_reg_a[`ITM_PRESC_MSB:0]),
    .tick(tick)
  );

  // ----------------------------------------------------------------------------
  // Counter and compare
  // ----------------------------------------------------------------------------
  // Compares use the count before this tick's update, so period D gives D+1 ticks
  assign period_hit = running & tick & (count == period_buffer); // see (R5) (R6)
  assign second_hit = running & tick & (count == secondary_buffer); // see (R7)

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count <= `ITM_IDLE_COUNT;
      running <= 1'b0;
      period_buffer <= `ITM_ZERO_COUNT;
      secondary_buffer <= `ITM_ZERO_COUNT;
      square_wave <= 1'b0;
      secondary_wave <= 1'b0;
      period_match_irq <= 1'b0;
      secondary_match_irq <= 1'b0;
    end else begin
      period_match_irq <= 1'b0;
      secondary_match_irq <= 1'b0;
      if (!counter_enable_bit || !interval_mode) begin
        count <= `ITM_IDLE_COUNT;
        running <= 1'b0;
        square_wave <= 1'b0;
        secondary_wave <= 1'b0;
        period_buffer <= period_compare_reg;
        secondary_buffer <= secondary_compare_reg;
      end else if (!running) begin
        if (tick) begin
          count <= `ITM_ZERO_COUNT; // see (R4)
          running <= 1'b1;
          square_wave <= ~square_wave;
          period_buffer <= period_compare_reg;
          secondary_buffer <= secondary_compare_reg;
        end
      end else begin
        // Anytime write: new compare values act on the next tick; see (R12)
        if (wr_period) begin
          period_buffer <= hwdata[15:0];
        end
        if (wr_second) begin
          secondary_buffer <= hwdata[15:0];
        end
        if (period_hit) begin
          count <= `ITM_ZERO_COUNT; // see (R10) (R11)
          period_match_irq <= 1'b1;
          if (out_control_reg[`ITM_SQ_EN_BIT]) begin
            square_wave <= ~square_wave; // see (R17)
          end
        end else if (tick) begin
          // Natural wrap past all ones when period was lowered; see (R13) (R18)
          count <= count + 16'h0001;
        end
        if (second_hit) begin
          secondary_match_irq <= 1'b1;
          if (out_control_reg[`ITM_SEC_EN_BIT]) begin
            secondary_wave <= ~secondary_wave;
          end
        end
      end
    end
  end

  assign square_wave_out = square_wave;
  assign square_wave_oe = out_control_reg[`ITM_SQ_EN_BIT];
  assign secondary_wave_out = secondary_wave;
  assign secondary_wave_oe = out_control_reg[`ITM_SEC_EN_BIT];

  // ----------------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------------
  itm_irq u_irq (
    .clk(clk),
    .rst_n(rst_sync_n),
    .set({secondary_match_irq, period_match_irq}),
    .clr_we(irq_clr_we),
    .clr_data(hwdata[1:0]),
    .mask(irq_mask),
    .status(irq_status),
    .irq(irq)
  );

endmodule
`default_nettype wire

// *** tb/itm_top_asserts.sv ***
// Port-level checks for the interval timer top.
// Assumes one AHB-Lite master and word transfers only.
`timescale 1ns/1ps
`default_nettype none

module itm_top_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ext_event_in,
  input wire logic capture_trigger_in,
  input wire logic square_wave_out,
  input wire logic square_wave_oe,
  input wire logic secondary_wave_out,
  input wire logic secondary_wave_oe,
  input wire logic period_match_irq,
  input wire logic secondary_match_irq,
  input wire logic irq
);
  logic dp_rd;
  logic dp_wr;
  logic [7:0] dp_off;
  logic ce_seen;
  wire mask_wr = dp_wr && dp_off == 8'h24;
  wire irq_wr = dp_wr && (dp_off == 8'h24 || dp_off == 8'h20);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------------
  // Bus shadow
  // ---------------------------------------------------------------------
  // Tracks the enable bit so quiet-when-stopped can be judged
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_rd <= 1'b0;
      dp_wr <= 1'b0;
      dp_off <= 8'h00;
      ce_seen <= 1'b0;
    end else begin
      dp_rd <= hsel && htrans[1] && hready && !hwrite;
      dp_wr <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready) begin
        dp_off <= haddr[7:0];
      end
      if (dp_wr && dp_off == 8'h00) begin
        ce_seen <= hwdata[7];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  AST_OKAY: assert property (hresp == 1'b0) else $error("response not OKAY");
  AST_ZERO_WAIT: assert property (hreadyout == 1'b1) else $error("wait state seen");
  AST_RD_UPPER: assert property (dp_rd |-> hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_RD_UNMAPPED: assert property (dp_rd && dp_off >= 8'h28 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_STOPPED_QUIET: assert property (!ce_seen && !$past(ce_seen)
    && !$past(ce_seen, 2) |-> !period_match_irq && !secondary_match_irq)
    else $error("event while stopped");
  AST_WAVE_STOPPED: assert property (!ce_seen && !$past(ce_seen)
    && !$past(ce_seen, 2) |-> !square_wave_out)
    else $error("wave high while stopped");
  AST_IRQ_RISE: assert property ($rose(irq) |->
    period_match_irq || secondary_match_irq ||
    $past(period_match_irq) || $past(secondary_match_irq) || $past(mask_wr) ||
    $past(mask_wr, 2)) else $error("irq rose without cause");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(irq_wr) || $past(irq_wr, 2))
    else $error("irq fell without clear");
  // Output enables move only when the output control word is written
  AST_OE_WRITE: assert property ($changed(square_wave_oe) || $changed(secondary_wave_oe)
    |-> $past(dp_wr) && $past(dp_off) == 8'h10)
    else $error("output enable changed without write");
endmodule

bind itm_top itm_top_asserts i_itm_top_asserts (.clk(clk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .ext_event_in(ext_event_in), .capture_trigger_in(capture_trigger_in),
  .square_wave_out(square_wave_out), .square_wave_oe(square_wave_oe),
  .secondary_wave_out(secondary_wave_out), .secondary_wave_oe(secondary_wave_oe),
  .period_match_irq(period_match_irq), .secondary_match_irq(secondary_match_irq), .irq(irq));

`default_nettype wire

// *** tb/test_itm_top.sv ***
// Directed regression of the interval timer through its AHB-Lite port.
// Assumes the bench is the only bus master and the prescaler passes every clock.
`timescale 1ns/1ps
`default_nettype none
`include "itm_map.vh"

module test_itm_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, sq, sq_oe, sw, sw_oe, pm, sm, irq;
  logic ext_ev = 1'b0;
  int swv[$];
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last;
  int pq[$];
  int sv[$];
  int smq[$];

  itm_top i_itm_top (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_event_in(ext_ev), .capture_trigger_in(1'b0),
    .square_wave_out(sq), .square_wave_oe(sq_oe), .secondary_wave_out(sw),
    .secondary_wave_oe(sw_oe), .period_match_irq(pm), .secondary_match_irq(sm), .irq(irq));

  always #25 clk = ~clk;

  // Pulse times and the square level at each period pulse
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pm === 1'b1) begin
      pq.push_back(cyc);
      sv.push_back(sq);
    end
    if (sm === 1'b1) begin
      smq.push_back(cyc);
      swv.push_back(sw);
    end
  end

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task print_verdict;
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        mismatches++;
        print_verdict();
      end
      @(posedge clk);
    end
  endtask

  task bus(input logic wr, input logic [7:0] off, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, off};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task wr(input logic [7:0] off, input logic [31:0] d);
    bus(1'b1, off, d);
  endtask

  task rdc(input string name, input logic [7:0] off, input logic [31:0] exp);
    bus(1'b0, off, 32'h0);
    check(name, rd, exp);
  endtask

  task chk_iv(input string name, input int q[$], input int e);
    check(name, q.size() >= 2, 1);
    for (int i = 1; i < q.size(); i++) check(name, q[i] - q[i-1], e);
  endtask

  // Long waits stay bounded; the lowered-period case needs a full wrap
  task wait_pulse(input int n);
    int k;
    k = 0;
    while (pq.size() <= n) begin
      @(posedge clk);
      k++;
      if (k > 70000) begin
        mismatches++;
        print_verdict();
      end
    end
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("count stopped", `ITM_OFF_COUNT, 32'h0);
    check("resp okay", hresp, 1'b0);
    rdc("mask reset", `ITM_OFF_IRQ_MASK, 32'h3);
    rdc("unmapped", 8'h28, 32'h0);
    wr(`ITM_OFF_IOC_ONE, {30'h0, `ITM_EDGE_NONE});
    wr(`ITM_OFF_OUT_CTL, 32'h3);
    wr(`ITM_OFF_PERIOD, 32'h2);
    wr(`ITM_OFF_SECOND, 32'h1);
    wr(`ITM_OFF_CTL_B, {29'h0, `ITM_MODE_INTERVAL});
    wr(`ITM_OFF_CTL_A, 32'h80);
    repeat (40) @(posedge clk);
    chk_iv("period interval", pq, 3);
    chk_iv("secondary interval", smq, 3);
    for (int i = 1; i < sv.size(); i++) check("square toggle", sv[i] ^ sv[i-1], 1);
    for (int i = 1; i < swv.size(); i++) check("sec toggle", swv[i] ^ swv[i-1], 1);
    check("square oe on", sq_oe, 1'b1);
    check("secondary oe on", sw_oe, 1'b1);
    rdc("status", `ITM_OFF_IRQ_STAT, 32'h3);
    check("irq masked", irq, 1'b0);
    wr(`ITM_OFF_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk);
    check("irq unmasked", irq, 1'b1);
    wr(`ITM_OFF_OUT_CTL, 32'h0);
    sv.delete();
    repeat (20) @(posedge clk);
    for (int i = 1; i < sv.size(); i++) check("square held", sv[i] ^ sv[i-1], 0);
    check("square oe off", sq_oe, 1'b0);
    check("secondary oe off", sw_oe, 1'b0);
    wr(`ITM_OFF_CTL_A, 32'h0);
    repeat (4) @(posedge clk);
    rdc("count cleared", `ITM_OFF_COUNT, 32'h0);
    wr(`ITM_OFF_IRQ_STAT, 32'h3);
    rdc("status cleared", `ITM_OFF_IRQ_STAT, 32'h0);
    check("irq cleared", irq, 1'b0);
    wr(`ITM_OFF_PERIOD, 32'h0);
    wr(`ITM_OFF_CTL_A, 32'h80);
    pq.delete();
    repeat (20) @(posedge clk);
    chk_iv("period zero", pq, 1);
    rdc("count zero", `ITM_OFF_COUNT, 32'h0);
    // External event as count clock: one rising edge every 8 clocks, period 1
    wr(`ITM_OFF_CTL_A, 32'h0);
    wr(`ITM_OFF_IOC_TWO, {30'h0, `ITM_EDGE_RISE});
    wr(`ITM_OFF_CTL_B, 32'h20);
    wr(`ITM_OFF_PERIOD, 32'h1);
    wr(`ITM_OFF_CTL_A, 32'h80);
    pq.delete();
    repeat (24) begin
      repeat (4) @(posedge clk);
      ext_ev <= ~ext_ev;
    end
    chk_iv("event interval", pq, 16);
    wr(`ITM_OFF_CTL_A, 32'h0);
    wr(`ITM_OFF_CTL_B, {29'h0, `ITM_MODE_INTERVAL});
    wr(`ITM_OFF_PERIOD, 32'd100);
    wr(`ITM_OFF_CTL_A, 32'h80);
    pq.delete();
    wait_pulse(0);
    repeat (50) @(posedge clk);
    bus(1'b0, `ITM_OFF_COUNT, 32'h0);
    check("count live", rd > 32'd10 && rd <= 32'd100, 1);
    wr(`ITM_OFF_PERIOD, 32'd10);
    last = pq[pq.size()-1];
    wait_pulse(pq.size());
    check("wrap interval", pq[pq.size()-1] - last, 32'h1000b);
    last = pq[pq.size()-1];
    wait_pulse(pq.size());
    check("new interval", pq[pq.size()-1] - last, 32'd11);
    print_verdict();
  end
endmodule

`default_nettype wire
